/* File: nvclk_params.svh */
`ifndef NVCLK_PARAMS_SVH
`define NVCLK_PARAMS_SVH
// address, data and sequence sizes
`define ADDR_W          21
`define DATA_W          8
`define SEQ_BITS        64
`define UNLOCK_LIMIT    21'h7ffff
// bit positions inside the hours register
`define HOURS_MODE_BIT  7
`define HOURS_PM_BIT    5
// bit position of the oscillator stop flag in the day register
`define DAY_OSC_BIT     5
// strobe timing in ns, counted at a 10 ns clock
`define CLK_NS          10
`define ACCESS_NS       100
`define STROBE_NS       70
`define RECOVERY_NS     10
`define ACCESS_CYC      ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_CYC      ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOVERY_CYC    ((`RECOVERY_NS + `CLK_NS - 1) / `CLK_NS)
`endif

/* File: nvclk_pkg.sv */
package nvclk_pkg;
   // user request carried into the controller
   typedef struct packed {
      logic [1:0]  op;
      logic [20:0] addr;
      logic [7:0]  data;
   } req_s;
   // operation codes
   typedef enum logic [1:0] {
      OP_READ  = 2'h0,
      OP_WRITE = 2'h1,
      OP_CLKRD = 2'h2,
      OP_CLKWR = 2'h3
   } op_e;
   // strobe sequencer states, one-hot
   typedef enum logic [5:0] {
      S_IDLE  = 6'h01,
      S_SETUP = 6'h02,
      S_PULSE = 6'h04,
      S_HOLD  = 6'h08,
      S_RECOV = 6'h10,
      S_DONE  = 6'h20
   } state_e;
endpackage

/* File: nvclk_host.sv */
`timescale 1ns/10ps
`include "nvclk_params.svh"
// Function
// - each access addresses one byte with a 21-bit address.
// - address held through write; strobe high for recovery before next.
// - output gate kept high during every write cycle.
// - unlock is 64 writes carrying a pattern on data bit 0.
// - unlock sequence opens with a read resetting the pointer.
// - unlock writes use one scratch address below 80000h.
// - clock registers move one bit per access on data bit 0, 64 accesses in all.
module nvclk_host
   import nvclk_pkg::*;
#(
   parameter logic [63:0] UNLOCK_PATTERN = 64'h0123456789abcdef,
   parameter logic [20:0] SCRATCH_ADDR   = 21'h00000,
   parameter int          ACCESS_CYC     = `ACCESS_CYC,
   parameter int          STROBE_CYC     = `STROBE_CYC,
   parameter int          RECOVERY_CYC   = `RECOVERY_CYC
)(
   input  wire logic        MCLK,      // system clock, 100 MHz
   input  wire logic        RST,       // async reset, active high
   input  wire logic        REQ_VALID, // request strobe
   output logic             REQ_READY, // controller idle
   input  wire req_s        REQ,       // operation, address, data
   input  wire logic [63:0] CLK_WDATA, // clock image to write
   output logic             DONE,      // one-cycle completion pulse
   output logic [7:0]       RDATA,     // byte read from memory
   output logic [63:0]      CLK_RDATA, // clock image read back
   output logic             POWER_OK,  // synchronised supply good
   input  wire logic        PWR_GOOD,  // supply above power_fail_threshold
   output logic [20:0]      ADDR,      // address_lines
   output logic             CE_N,      // chip select, active low
   output logic             OE_N,      // output gate, active low
   output logic             WE_N,      // write strobe, active low
   input  wire logic [7:0]  DQ_I,      // data bus in
   output logic [7:0]       DQ_O,      // data bus out
   output logic             DQ_OE      // high while driving data bus
);
   state_e      state, next_state;
   logic [7:0]  cnt, next_cnt;
   logic [7:0]  seq, next_seq;   // cycle index in clock access
   logic        is_wr, next_is_wr;
   logic        clk_op, next_clk_op;
   logic [20:0] addr_q, next_addr;
   logic [7:0]  data_q, next_data;
   logic [7:0]  rdata_q, next_rdata;
   logic [63:0] wimg, next_wimg;
   logic [63:0] rimg, next_rimg;
   logic [2:0]  pf_sync;
   logic        power_ok, next_power_ok;
   logic        is_wr_req, next_is_wr_req; // direction of transfer phase

   // index in clock sequence: 0 read, 1..64 pattern, 65..128 transfer
   function automatic logic seq_bit(input logic [7:0] s,
                                    input logic [63:0] w);
      logic [7:0] i;
      i = 8'h00;
      if (s <= 8'h40) begin
         i = s - 8'h01;
         seq_bit = UNLOCK_PATTERN[i[5:0]];
      end else begin
         i = s - 8'h41;
         seq_bit = w[i[5:0]];
      end
   endfunction

   // power-good pin synchroniser, three stages
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pf_sync  <= 3'h0;
         power_ok <= 1'b0;
      end else begin
         pf_sync  <= {pf_sync[1:0], PWR_GOOD};
         power_ok <= next_power_ok;
      end
   end

   // supply state changes only once the last two stages agree
   always_comb begin
      next_power_ok = power_ok;
      if (pf_sync[2] == pf_sync[1]) begin
         next_power_ok = pf_sync[2];
      end
   end
   assign POWER_OK = power_ok;

   // next-state logic of the strobe sequencer
   always_comb begin
      next_state  = state;
      next_cnt    = cnt;
      next_seq    = seq;
      next_is_wr  = is_wr;
      next_clk_op = clk_op;
      next_addr   = addr_q;
      next_data   = data_q;
      next_rdata  = rdata_q;
      next_wimg   = wimg;
      next_rimg   = rimg;
      unique case (state)
         S_IDLE: begin
            if (REQ_VALID && POWER_OK) begin
               next_clk_op = REQ.op[1];
               next_addr   = REQ.addr;
               next_data   = REQ.data;
               next_is_wr  = REQ.op[0];
               next_wimg   = CLK_WDATA;
               next_seq    = 8'h00;
               next_cnt    = 8'h00;
               // clock ops open with a read at the scratch location
               if (REQ.op[1]) begin
                  next_addr  = SCRATCH_ADDR;
                  next_is_wr = 1'b0;
               end
               next_state = S_SETUP;
            end
         end
         S_SETUP: begin
            next_state = S_PULSE;
         end
         S_PULSE: begin
            next_cnt = cnt + 8'h01;
            if (cnt == 8'((is_wr ? STROBE_CYC : ACCESS_CYC) - 1)) begin
               next_cnt = 8'h00;
               // read data is taken on the last cycle of the pulse
               if (!is_wr) begin
                  next_rdata = DQ_I;
                  if (clk_op && seq > 8'h40) begin
                     next_rimg[6'(seq - 8'h41)] = DQ_I[0];
                  end
               end
               next_state = S_HOLD;
            end
         end
         S_HOLD: begin
            next_state = S_RECOV;
         end
         S_RECOV: begin
            next_cnt = cnt + 8'h01;
            if (cnt >= 8'(RECOVERY_CYC - 1)) begin
               next_cnt = 8'h00;
               if (clk_op && seq != 8'h80 && POWER_OK) begin
                  next_seq = seq + 8'h01;
                  // pattern phase writes; transfer follows op direction
                  next_is_wr = (seq < 8'h40) ? 1'b1 : clk_op & is_wr_req;
                  next_data  = {7'h00, seq_bit(seq + 8'h01, wimg)};
                  next_state = S_SETUP;
               end else begin
                  next_state = S_DONE;
               end
            end
         end
         S_DONE: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // remember whether the clock op asked to read or to write
   always_comb begin
      next_is_wr_req = is_wr_req;
      if (state == S_IDLE && REQ_VALID && POWER_OK) begin
         next_is_wr_req = REQ.op[0];
      end
   end

   // state registers
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state     <= S_IDLE;
         cnt       <= 8'h00;
         seq       <= 8'h00;
         is_wr     <= 1'b0;
         is_wr_req <= 1'b0;
         clk_op    <= 1'b0;
         addr_q    <= 21'h00000;
         data_q    <= 8'h00;
         rdata_q   <= 8'h00;
         wimg      <= 64'h0;
         rimg      <= 64'h0;
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         seq       <= next_seq;
         is_wr     <= next_is_wr;
         is_wr_req <= next_is_wr_req;
         clk_op    <= next_clk_op;
         addr_q    <= next_addr;
         data_q    <= next_data;
         rdata_q   <= next_rdata;
         wimg      <= next_wimg;
         rimg      <= next_rimg;
      end
   end

   // pin drive; address stable from setup through hold
   assign ADDR      = addr_q;
   assign CE_N      = !(state == S_PULSE);
   assign WE_N      = !(state == S_PULSE && is_wr);
   assign OE_N      = !(state == S_PULSE && !is_wr);
   assign DQ_O      = data_q;
   assign DQ_OE     = is_wr && (state == S_SETUP || state == S_PULSE
                                || state == S_HOLD);
   assign REQ_READY = (state == S_IDLE);
   assign DONE      = (state == S_DONE);
   assign RDATA     = rdata_q;
   assign CLK_RDATA = rimg;
endmodule

/* File: nvclk_host_chk.sv */
`timescale 1ns/10ps
module nvclk_host_chk (
   input wire logic        MCLK,     // system clock
   input wire logic        RST,      // async reset
   input wire logic        POWER_OK, // supply good
   input wire logic [20:0] ADDR,     // address_lines
   input wire logic        CE_N,     // chip select
   input wire logic        OE_N,     // output gate
   input wire logic        WE_N,     // write strobe
   input wire logic        DQ_OE     // host drives bus
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   // strobe pulse shapes
   sequence s_write; (!CE_N && !WE_N && DQ_OE) [*7]; endsequence
   sequence s_read; (!CE_N && !OE_N && WE_N) [*8]; endsequence
   property p_write_pulse; $fell(WE_N) |-> s_write; endproperty
   property p_read_pulse; $fell(OE_N) |-> s_read; endproperty
   property p_no_clash; !OE_N |-> WE_N && !DQ_OE; endproperty
   property p_addr_hold; !CE_N |-> $stable(ADDR); endproperty
   property p_recovery; $rose(WE_N) |-> WE_N [*3]; endproperty
   property p_release; $rose(CE_N) |-> WE_N && OE_N; endproperty
   property p_power_block;
      !POWER_OK && !$past(POWER_OK) && CE_N |=> CE_N;
   endproperty
   property p_cycle_end; $fell(CE_N) |-> ##[1:12] CE_N; endproperty
   a_write_pulse: assert property (p_write_pulse)
      else $error("write pulse short");
   a_read_pulse: assert property (p_read_pulse)
      else $error("read pulse short");
   a_no_clash: assert property (p_no_clash)
      else $error("bus contention");
   a_addr_hold: assert property (p_addr_hold)
      else $error("address moved in cycle");
   a_recovery: assert property (p_recovery)
      else $error("recovery too short");
   a_release: assert property (p_release)
      else $error("select left before strobe");
   a_power_block: assert property (p_power_block)
      else $error("access while power bad");
   a_cycle_end: assert property (p_cycle_end)
      else $error("cycle never ended");
endmodule
bind nvclk_host nvclk_host_chk u_chk (.MCLK, .RST, .POWER_OK, .ADDR,
   .CE_N, .OE_N, .WE_N, .DQ_OE);

/* File: nvclk_dev.sv */
`timescale 1ns/10ps
module nvclk_dev
   import nvclk_pkg::*;
#(parameter logic [63:0] PAT = 64'h0123456789abcdef) (
   input  wire logic [20:0] ADDR,     // address_lines
   input  wire logic        CE_N,     // chip select
   input  wire logic        OE_N,     // output gate
   input  wire logic        WE_N,     // write strobe
   input  wire logic        PWR_GOOD, // supply above threshold
   input  wire logic [7:0]  DQ_O,     // host data
   input  wire logic        DQ_OE,    // host drives bus
   output logic      [7:0]  DQ_I      // resolved bus level
);
   logic [7:0]  mem [int];
   logic [63:0] clk_reg = '0;
   int          ptr = -1;
   int          xfer = 0;
   wire         wr = PWR_GOOD && !CE_N && !WE_N;
   wire         rd = PWR_GOOD && !CE_N && WE_N;
   // write lands at the first strobe release
   always @(negedge wr) if ($time > 0) begin
      if (xfer > 0) begin
         clk_reg[64 - xfer] = DQ_O[0];
         xfer--;
      end else begin
         mem[ADDR] = DQ_O;
         if (ADDR <= 21'h7ffff && ptr >= 0) begin
            if (DQ_O[0] == PAT[ptr]) ptr++;
            else ptr = -1;
            if (ptr == 64) begin
               xfer = 64;
               ptr  = -1;
            end
         end
      end
   end
   // read end steps the transfer or restarts recognition
   always @(negedge rd) if ($time > 0) begin
      if (xfer > 0) xfer--;
      else ptr = 0;
   end
   // released bus shows the inverse of the host's last data
   always @* begin
      if (DQ_OE) DQ_I = DQ_O;
      else if (rd && !OE_N) DQ_I = xfer > 0 ? {7'h00, clk_reg[64 - xfer]}
         : (mem.exists(ADDR) ? mem[ADDR] : 8'h00);
      else DQ_I = ~DQ_O;
   end
endmodule

/* File: nvclk_host_tb.sv */
`timescale 1ns/10ps
`include "nvclk_params.svh"
module nvclk_host_tb import nvclk_pkg::*;;
   logic        MCLK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, PWR_GOOD = 1'b1;
   req_s        REQ = '0;
   logic [63:0] CLK_WDATA = '0, CLK_RDATA;
   logic        REQ_READY, DONE, POWER_OK, CE_N, OE_N, WE_N, DQ_OE;
   logic [7:0]  RDATA, DQ_I, DQ_O;
   logic [20:0] ADDR;
   int          n_mismatch = 0, tests_run = 0;
   nvclk_host dut (.MCLK, .RST, .REQ_VALID, .REQ_READY, .REQ, .CLK_WDATA,
      .DONE, .RDATA, .CLK_RDATA, .POWER_OK, .PWR_GOOD, .ADDR, .CE_N,
      .OE_N, .WE_N, .DQ_I, .DQ_O, .DQ_OE);
   nvclk_dev dev (.ADDR, .CE_N, .OE_N, .WE_N, .PWR_GOOD, .DQ_O, .DQ_OE,
      .DQ_I);
   initial forever #5 MCLK = ~MCLK;
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one request, bounded waits for take and completion
   task automatic op(input op_e o, input logic [20:0] a, input logic [7:0] d);
      int i, j;
      @(posedge MCLK);
      REQ       <= '{o, a, d};
      REQ_VALID <= 1'b1;
      i = 0;
      do @(negedge MCLK);
      while ((REQ_READY && POWER_OK) !== 1'b1 && ++i < 40);
      @(posedge MCLK);
      REQ_VALID <= 1'b0;
      j = 0;
      do @(negedge MCLK);
      while (DONE !== 1'b1 && ++j < 3000);
      if (i >= 40 || j >= 3000) begin
         n_mismatch++;
         end_of_test();
      end
   endtask
   initial begin
      repeat (10) @(posedge MCLK);
      RST <= 1'b0;
      op(OP_WRITE, 21'h1abcd, 8'h5a);
      op(OP_WRITE, 21'h1fffff, 8'ha5);
      op(OP_READ, 21'h1abcd, 8'h00);
      check(RDATA, 8'h5a);
      check(dev.mem[21'h1abcd], 8'h5a);
      op(OP_READ, 21'h1fffff, 8'h00);
      check(RDATA, 8'ha5);
      $display("memory test done");
      @(posedge MCLK);
      CLK_WDATA <= 64'h2304_1206_8519_3042;
      op(OP_CLKWR, 21'h0, 8'h00);
      check(dev.clk_reg, 64'h2304_1206_8519_3042);
      check(dev.mem[21'h1abcd], 8'h5a);
      CLK_WDATA <= '0;
      op(OP_CLKRD, 21'h0, 8'h00);
      check(CLK_RDATA, 64'h2304_1206_8519_3042);
      check(CLK_RDATA[24 + `HOURS_MODE_BIT], 1'b1);
      check(CLK_RDATA[24 + `HOURS_PM_BIT], 1'b0);
      check(CLK_RDATA[32 + `DAY_OSC_BIT], 1'b0);
      $display("clock test done");
      @(posedge MCLK);
      PWR_GOOD  <= 1'b0;
      REQ       <= '{OP_WRITE, 21'h1abcd, 8'h00};
      REQ_VALID <= 1'b1;
      repeat (20) @(posedge MCLK);
      // request still raised; nothing may start while supply is bad
      repeat (8) begin
         @(negedge MCLK);
         check(CE_N, 1'b1);
      end
      @(posedge MCLK);
      REQ_VALID <= 1'b0;
      check(POWER_OK, 1'b0);
      check(dev.mem[21'h1abcd], 8'h5a);
      PWR_GOOD  <= 1'b1;
      op(OP_READ, 21'h1abcd, 8'h00);
      check(RDATA, 8'h5a);
      $display("power test done");
      end_of_test();
   end
endmodule
